// >>> dv/autoreload_pwm_deadtime_break_tb_top.sv
// Self-checking bench for the PWM timer
`timescale 1ns/1ns
`include "pwm_timer_defs.vh"
module autoreload_pwm_deadtime_break_tb_top;
  logic pclk, presetn, psel, penable, pwrite, er;
  logic [5:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0] trip;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [1:0] brk, brk_alt;
  wire [3:0] pwm_out;
  int n_errors, compares, o0;
  pwm_timer #(.SLOW_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .break_input(brk), .break_alt_input(brk_alt),
    .pwm_out(pwm_out));
  pwm_stage_model u_stage (.pclk(pclk), .pwm_out(pwm_out), .trip(trip),
    .break_input(brk), .break_alt_input(brk_alt));
  ////////////////////
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // One transfer; request held until pready seen high
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rc(input logic [5:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask
  // Windows of 64 cycles hold whole periods of 16 and 8
  task mc(input int c, input int e);
    int k;
    k = 0;
    repeat (64) begin
      @(posedge pclk);
      if (pwm_out[c] === 1'b1) k++;
    end
    chk("pwm high cycles", e, k);
  endtask
  task stop_test;
    $display("counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Run needs about 5100 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    $display("unexpected timeout: expected end seen hang");
    stop_test();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, trip} = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`OFS_CTRL, `CTRL_RESET);
    apb(1'b0, 6'h34, 32'h0);
    chk("unmapped error", 32'h1, er);
    $display("test reset done");
    apb(1'b1, `OFS_ARR1, 32'hFF0);
    apb(1'b1, `OFS_ARR2, 32'hFF8);
    apb(1'b1, `OFS_DUTY0, 32'hFF8);
    apb(1'b1, `OFS_DUTY1, 32'hFF4);
    apb(1'b1, `OFS_DUTY2, 32'hFFC);
    apb(1'b1, `OFS_DUTY3, 32'hFFF);
    apb(1'b1, `OFS_OUTCTL, 32'h27);
    apb(1'b1, `OFS_CTRL, 32'h07);
    // First wrap of either counter takes 4096 cycles
    repeat (4200) @(posedge pclk);
    mc(0, 36);
    mc(1, 44);
    mc(2, 40);
    mc(3, 0);
    apb(1'b1, `OFS_CTRL, 32'h05);
    apb(1'b1, `OFS_DUTY0, 32'hFF2);
    repeat (40) @(posedge pclk);
    mc(0, 36);
    apb(1'b1, `OFS_CTRL, 32'h0F);
    repeat (40) @(posedge pclk);
    mc(0, 12);
    $display("test pwm done");
    apb(1'b1, `OFS_OUTCTL, 32'h07);
    apb(1'b1, `OFS_DEADTIME, 32'h82);
    repeat (40) @(posedge pclk);
    o0 = u_stage.overlaps;
    mc(0, 4);
    mc(1, 44);
    chk("overlap cycles", o0, u_stage.overlaps);
    apb(1'b1, `OFS_DEADTIME, 32'h80);
    repeat (40) @(posedge pclk);
    mc(0, 0);
    mc(1, 0);
    apb(1'b1, `OFS_DEADTIME, 32'h00);
    $display("test dead time done");
    apb(1'b1, `OFS_BRKEN, 32'h03);
    apb(1'b1, `OFS_BRK1, 32'hD8);
    repeat (3) @(posedge pclk);
    chk("pwm_out", 32'h5, pwm_out);
    rc(`OFS_STATUS, 32'h0);
    rc(`OFS_ARR1, 32'h0);
    rc(`OFS_DUTY0, 32'h0);
    apb(1'b1, `OFS_BRK1, 32'h00);
    repeat (8) @(posedge pclk);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("counter moving", 32'h1, rd != 32'h0);
    apb(1'b1, `OFS_BRK1, 32'hF5);
    trip <= 2'b01;
    repeat (3) @(posedge pclk);
    chk("pwm_out", 32'h7, pwm_out);
    trip <= 2'b00;
    rc(`OFS_BRK1, 32'hFD);
    apb(1'b1, `OFS_BRK1, 32'h00);
    rc(`OFS_BRK1, 32'h00);
    apb(1'b1, `OFS_BRK2, 32'h07);
    trip <= 2'b01;
    repeat (3) @(posedge pclk);
    rc(`OFS_BRK2, 32'h07);
    trip <= 2'b10;
    repeat (3) @(posedge pclk);
    trip <= 2'b00;
    rc(`OFS_BRK2, 32'h0F);
    $display("test break done");
    stop_test();
  end
endmodule // autoreload_pwm_deadtime_break_tb_top

// >>> dv/pwm_stage_model.sv
// Half-bridge stage and break sources facing the PWM timer
`timescale 1ns/1ns
module pwm_stage_model (
  input wire pclk,
  input wire [3:0] pwm_out,
  input wire [1:0] trip,
  output wire [1:0] break_input,
  output wire [1:0] break_alt_input
);
  int overlaps = 0;
  // Fault lines idle low, so a high-active break stays quiet
  assign break_input = {2{trip[0]}};
  assign break_alt_input = {2{trip[1]}};
  // Both switches of the leg on would short the supply
  always @(posedge pclk) begin
    if (pwm_out[0] === 1'b1 && pwm_out[1] === 1'b1) overlaps++;
  end
endmodule // pwm_stage_model

// >>> dv/pwm_timer_sva.sv
// Port checker for the PWM timer register bus
`timescale 1ns/1ns
`include "pwm_timer_defs.vh"
module pwm_timer_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [1:0] break_input,
  input wire [1:0] break_alt_input,
  input wire [3:0] pwm_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded bus phases; bad is anything past the last register
  wire rd_setup = psel && !penable && !pwrite;
  wire acc = psel && penable;
  wire bad = paddr > `OFS_STATUS;
  ////////////////////
  ready_const_a: assert property (pready) else $error("pready low");
  err_bad_a: assert property (acc && bad |-> pslverr) else $error("unmapped not flagged");
  err_idle_a: assert property (!acc |-> !pslverr) else $error("error outside access");
  err_good_a: assert property (acc && !bad && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped flagged");
  rd_bad_a: assert property (rd_setup && bad |=> prdata == 32'h0) else $error("unmapped data");
  rd_ctrl_a:
    assert property (rd_setup && paddr == `OFS_CTRL |=> prdata[31:6] == 26'h0
      && prdata[4:3] == 2'b00) else $error("ctrl readback");
  rd_arr_a:
    assert property (rd_setup && paddr == `OFS_ARR1 |=> prdata[31:12] == 20'h0)
    else $error("reload width");
  rd_hold_a: assert property (!psel |=> $stable(prdata)) else $error("read data moved");
endmodule // pwm_timer_sva
bind pwm_timer pwm_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .break_input(break_input),
  .break_alt_input(break_alt_input), .pwm_out(pwm_out));

// >>> hw/pwm_timer.v
// Dual 12-bit autoreload PWM timer with dead time, polarity and break, APB slave
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "pwm_timer_defs.vh"
module pwm_timer #(
  parameter CW = 12,
  parameter SLOW_CYCLES = `TIMEBASE_US * `CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [1:0] break_input,
  input wire [1:0] break_alt_input,
  output reg [3:0] pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Channel k follows counter2 only in dual mode, upper pair
  function sel_cnt2;
    input integer k;
    input cnt2_en;
    begin
      sel_cnt2 = cnt2_en && (k >= 2);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [5:0] ctrl_q;
  reg [CW-1:0] arr1_q;
  reg [CW-1:0] arr2_q;
  reg [CW-1:0] duty_pre_q [0:3];
  reg [CW-1:0] duty_act_q [0:3];
  reg [3:0] output_enable_q;
  reg [3:0] pol_pre_q;
  reg [3:0] pol_act_q;
  reg [7:0] dead_time_reg_q;
  reg [7:0] dt_act_q;
  reg [7:0] brk1_q;
  reg [2:0] brk2_q;
  reg [1:0] break_active_q;
  reg [1:0] brk_cnt_en_q;
  reg [CW-1:0] cnt1_q;
  reg [CW-1:0] cnt2_q;
  reg [16:0] slow_q;
  reg [3:0] raw_q;
  reg raw0_prev_q;
  reg [6:0] dt_left_q;
  reg [1:0] force_q;

  wire counter2_enable = ctrl_q[`CTRL_CNT2_EN];
  wire slow_mode = ctrl_q[`CTRL_SLOW];
  wire wr_en = psel & penable & pwrite;
  wire setup = psel & ~penable;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  reg addr_ok;
  always @* begin
    case (paddr)
      `OFS_CTRL, `OFS_ARR1, `OFS_ARR2, `OFS_DUTY0, `OFS_DUTY1, `OFS_DUTY2,
      `OFS_DUTY3, `OFS_OUTCTL, `OFS_DEADTIME, `OFS_BRK1, `OFS_BRK2,
      `OFS_BRKEN, `OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait state; unmapped addresses error in access phase
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Read data captured at setup so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `OFS_CTRL: prdata <= {26'h0, ctrl_q[`CTRL_SLOW], 2'b00, ctrl_q[2:0]};
        `OFS_ARR1: prdata <= {20'h0, arr1_q};
        `OFS_ARR2: prdata <= {20'h0, arr2_q};
        `OFS_DUTY0: prdata <= {20'h0, duty_pre_q[0]};
        `OFS_DUTY1: prdata <= {20'h0, duty_pre_q[1]};
        `OFS_DUTY2: prdata <= {20'h0, duty_pre_q[2]};
        `OFS_DUTY3: prdata <= {20'h0, duty_pre_q[3]};
        `OFS_OUTCTL: prdata <= {24'h0, pol_pre_q, output_enable_q};
        `OFS_DEADTIME: prdata <= {24'h0, dead_time_reg_q};
        `OFS_BRK1: prdata <= {24'h0, brk1_q[7:4], break_active_q[0], brk1_q[2:0]};
        `OFS_BRK2: prdata <= {28'h0, break_active_q[1], brk2_q};
        `OFS_BRKEN: prdata <= {30'h0, brk_cnt_en_q};
        `OFS_STATUS: prdata <= {4'h0, cnt2_q, 4'h0, cnt1_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break detection and gating

  wire [1:0] brk_pin_en = {brk2_q[`BRK_PIN_EN], brk1_q[`BRK_PIN_EN]};
  wire [1:0] brk_src = {brk2_q[`BRK_SRC_SEL], brk1_q[`BRK_SRC_SEL]};
  wire [1:0] brk_lvl = {brk2_q[`BRK_LEVEL], brk1_q[`BRK_LEVEL]};
  wire [1:0] brk_sel_in = (brk_src & break_alt_input) | (~brk_src & break_input);
  wire [1:0] brk_hit = brk_pin_en & ~(brk_sel_in ^ brk_lvl);
  wire brk_any = |break_active_q;
  wire brk_a = brk_any & brk_cnt_en_q[0];
  wire brk_b = brk_any & (counter2_enable ? brk_cnt_en_q[1] : brk_cnt_en_q[0]);
  wire brk_on = brk_a | brk_b;
  wire wr_brk1 = wr_en && (paddr == `OFS_BRK1);
  wire wr_brk2 = wr_en && (paddr == `OFS_BRK2);

  // Hardware set beats a software clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_active_q <= 2'b00;
    end else begin
      break_active_q[0] <= brk_hit[0] |
        (wr_brk1 ? pwdata[`BRK_ACTIVE] : break_active_q[0]);
      break_active_q[1] <= brk_hit[1] |
        (wr_brk2 ? pwdata[`BRK_ACTIVE] : break_active_q[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and counters

  wire slow_tick = (slow_q == SLOW_CYCLES[16:0] - 17'h00001);
  wire adv = slow_mode ? slow_tick : 1'b1;
  wire adv1 = adv & ~brk_a;
  wire adv2 = adv & ~brk_b & counter2_enable;
  wire ovf1 = (adv1 && cnt1_q == `CNT_MAX) || force_q[0];
  wire ovf2 = ((adv2 && cnt2_q == `CNT_MAX) || force_q[1]) && counter2_enable;

  // Divider for the slow timebase tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_q <= 17'h00000;
    end else if (!slow_mode || slow_tick) begin
      slow_q <= 17'h00000;
    end else begin
      slow_q <= slow_q + 17'h00001;
    end
  end

  // Counters reload from autoreload, so period is 4096 minus it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt1_q <= `CNT_ZERO;
      cnt2_q <= `CNT_ZERO;
    end else begin
      if (brk_a) begin
        cnt1_q <= `CNT_ZERO;
      end else if (ovf1) begin
        cnt1_q <= arr1_q;
      end else if (adv1) begin
        cnt1_q <= cnt1_q + 12'h001;
      end
      if (brk_b || !counter2_enable) begin
        cnt2_q <= `CNT_ZERO;
      end else if (ovf2) begin
        cnt2_q <= arr2_q;
      end else if (adv2) begin
        cnt2_q <= cnt2_q + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      force_q <= 2'b00;
      arr1_q <= `CNT_ZERO;
      arr2_q <= `CNT_ZERO;
      output_enable_q <= 4'h0;
      pol_pre_q <= 4'h0;
      dead_time_reg_q <= 8'h00;
      brk1_q <= 8'h00;
      brk2_q <= 3'h0;
      brk_cnt_en_q <= 2'b00;
    end else begin
      force_q <= 2'b00;
      if (wr_en) begin
        case (paddr)
          `OFS_CTRL: begin
            ctrl_q <= {pwdata[`CTRL_SLOW], 2'b00, pwdata[2:0]};
            force_q <= {pwdata[`CTRL_FORCE2], pwdata[`CTRL_FORCE1]};
          end
          `OFS_OUTCTL: begin
            output_enable_q <= pwdata[3:0];
            pol_pre_q <= pwdata[7:4];
          end
          `OFS_DEADTIME: dead_time_reg_q <= pwdata[7:0];
          `OFS_BRK1: brk1_q <= pwdata[7:0];
          `OFS_BRK2: brk2_q <= pwdata[2:0];
          `OFS_BRKEN: brk_cnt_en_q <= pwdata[1:0];
          default: ;
        endcase
      end
      // Break holds reloads at reset value and wins over writes
      if (brk_on) begin
        arr1_q <= `CNT_ZERO;
        arr2_q <= `CNT_ZERO;
      end else if (wr_en && paddr == `OFS_ARR1) begin
        arr1_q <= pwdata[CW-1:0];
      end else if (wr_en && paddr == `OFS_ARR2) begin
        arr2_q <= pwdata[CW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel duty, polarity and raw waveform

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_ch
      wire use2 = sel_cnt2(k, counter2_enable);
      wire ch_ovf = use2 ? ovf2 : ovf1;
      wire ch_tran = use2 ? ctrl_q[`CTRL_SECONDARY_TRANSFER_ENABLE] : ctrl_q[`CTRL_PRIMARY_TRANSFER_ENABLE];
      wire [CW-1:0] ch_cnt = use2 ? cnt2_q : cnt1_q;
      localparam integer DUTY_OFS_I = `OFS_DUTY0 + k * 4;
      wire [5:0] duty_ofs = DUTY_OFS_I[5:0];

      // Preload, transfer at overflow when enabled
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          duty_pre_q[k] <= `CNT_ZERO;
          duty_act_q[k] <= `CNT_ZERO;
          pol_act_q[k] <= 1'b0;
        end else if (brk_on) begin
          duty_pre_q[k] <= `CNT_ZERO;
          duty_act_q[k] <= `CNT_ZERO;
        end else begin
          if (wr_en && paddr == duty_ofs) begin
            duty_pre_q[k] <= pwdata[CW-1:0];
          end
          if (ch_ovf && ch_tran) begin
            duty_act_q[k] <= duty_pre_q[k];
            pol_act_q[k] <= pol_pre_q[k];
          end
        end
      end

      // High at overflow, low at duty match; needs duty at or above reload
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          raw_q[k] <= 1'b0;
        end else if (ch_ovf) begin
          raw_q[k] <= 1'b1;
        end else if (ch_cnt == duty_act_q[k]) begin
          raw_q[k] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Dead time on the first pair

  wire [6:0] dt_count = dt_act_q[`DT_CNT_MSB:0];
  wire dt_en = dt_act_q[`DT_EN] & ~slow_mode;
  wire dt_zero = dt_act_q[`DT_EN] && (dt_count == 7'h00);
  wire raw0_edge = raw_q[0] ^ raw0_prev_q;

  // Setting buffered so a cycle in progress is not deformed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_act_q <= 8'h00;
    end else if (ovf1) begin
      dt_act_q <= dead_time_reg_q;
    end
  end

  // Gap counted in primary counter ticks after each raw edge;
  // the edge cycle itself is the first tick of the gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw0_prev_q <= 1'b0;
      dt_left_q <= 7'h00;
    end else begin
      raw0_prev_q <= raw_q[0];
      if (raw0_edge) begin
        dt_left_q <= dt_count - 7'h01;
      end else if (adv1 && dt_left_q != 7'h00) begin
        dt_left_q <= dt_left_q - 7'h01;
      end
    end
  end

  // Output 0 rises gap after overflow, output 1 gap after duty match
  wire gap_over = ~raw0_edge & (dt_left_q == 7'h00);
  wire [1:0] pair_dt = {~raw_q[0] & gap_over, raw_q[0] & gap_over};
  wire [1:0] pair = dt_zero ? 2'b00 : (dt_en ? pair_dt : raw_q[1:0]);
  // Inversion follows dead time, so inverted pair may overlap
  wire [3:0] shaped = {raw_q[3:2], pair} ^ pol_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: break pattern after inverter, enables last

  wire [3:0] brk_mask = {brk_b, brk_b, brk_a, brk_a};
  wire [3:0] pattern = brk1_q[`BRK_PAT_MSB:`BRK_PAT_LSB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 4'h0;
    end else begin
      pwm_out <= output_enable_q &
        ((brk_mask & pattern) | (~brk_mask & shaped));
    end
  end

endmodule // pwm_timer

// >>> include/pwm_timer_defs.vh
// Constants for the autoreload PWM timer with dead time and break
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// Register byte offsets on APB
`define OFS_CTRL 6'h00
`define OFS_ARR1 6'h04
`define OFS_ARR2 6'h08
`define OFS_DUTY0 6'h0C
`define OFS_DUTY1 6'h10
`define OFS_DUTY2 6'h14
`define OFS_DUTY3 6'h18
`define OFS_OUTCTL 6'h1C
`define OFS_DEADTIME 6'h20
`define OFS_BRK1 6'h24
`define OFS_BRK2 6'h28
`define OFS_BRKEN 6'h2C
`define OFS_STATUS 6'h30

// Control register fields
`define CTRL_CNT2_EN 0
`define CTRL_PRIMARY_TRANSFER_ENABLE 1
`define CTRL_SECONDARY_TRANSFER_ENABLE 2
`define CTRL_FORCE1 3
`define CTRL_FORCE2 4
`define CTRL_SLOW 5
`define CTRL_RESET 6'h06

// Break control fields
`define BRK_PIN_EN 0
`define BRK_SRC_SEL 1
`define BRK_LEVEL 2
`define BRK_ACTIVE 3
`define BRK_PAT_LSB 4
`define BRK_PAT_MSB 7

// Dead time register fields
`define DT_EN 7
`define DT_CNT_MSB 6

// Counter limits
`define CNT_MAX 12'hFFF
`define CNT_ZERO 12'h000
`define STATUS_CNT2_LSB 16

// Slow timebase: period in microseconds, clock in MHz
`define TIMEBASE_US 1000
`define CLK_MHZ 100

`endif
